// ==== src/poca_seq.sv ====
// Step sequencer for the adder datapath, commanded by software over APB.
// Assumes an APB master on the same clock and the adder on the far side of poca_if.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module poca_seq
  import poca_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  poca_if.ctl              bus
);

  poca_state_e      state_reg;
  poca_state_e      state_next;
  logic [3:0]       cnt_reg;
  logic [3:0]       cnt_next;
  poca_op_e         op_reg;
  poca_op_e         op_next;
  logic             signed_reg;
  logic             signed_next;
  logic [WIDTH-1:0] opa_reg;
  logic [WIDTH-1:0] opa_next;
  logic [WIDTH-1:0] opb_reg;
  logic [WIDTH-1:0] opb_next;
  logic             ovf_seen_reg;
  logic             ovf_seen_next;
  logic             fin_reg;
  logic             fin_next;
  logic             pready_reg;
  logic             pready_next;
  logic [31:0]      prdata_reg;
  logic [31:0]      prdata_next;
  logic             pslverr_reg;
  logic             pslverr_next;
  logic             start_req;
  logic             man_clr;
  logic [9:0]       strobe_reg;
  logic [9:0]       strobe_next;
  logic [WIDTH-1:0] operand_reg;
  logic [WIDTH-1:0] operand_next;
  logic             mapped;
  logic             commit;

  assign mapped = (paddr == REG_CTRL) || (paddr == REG_OPA) || (paddr == REG_OPB) ||
                  (paddr == REG_STATUS) || (paddr == REG_RESULT);
  // Writes take effect at the edge where pready is seen high, as the master expects.
  assign commit    = psel & penable & pready_reg & pwrite & mapped;
  assign start_req = commit && paddr == REG_CTRL && pwdata[CTRL_START_BIT] &&
                     state_reg == ST_IDLE;
  assign man_clr   = commit && paddr == REG_CTRL && pwdata[CTRL_OVFCLR_BIT];

  // Register slave group, one wait state on every access.
  always_comb
  begin
    pready_next  = psel & penable & ~pready_reg;
    prdata_next  = 32'h0000_0000;
    pslverr_next = psel & penable & ~pready_reg & ~mapped;
    op_next      = op_reg;
    signed_next  = signed_reg;
    opa_next     = opa_reg;
    opb_next     = opb_reg;
    if (psel && penable && !pready_reg && !pwrite)
    begin
      case (paddr)
        REG_CTRL:   prdata_next = {28'h0, signed_reg, op_reg, 1'b0};
        REG_OPA:    prdata_next = {24'h0, opa_reg};
        REG_OPB:    prdata_next = {24'h0, opb_reg};
        REG_STATUS: prdata_next = {29'h0, ovf_seen_reg, fin_reg, state_reg != ST_IDLE};
        REG_RESULT: prdata_next = {24'h0, bus.sum};
        default:    prdata_next = 32'h0000_0000;
      endcase
    end
    // Mode and operation stay frozen while a sequence runs.
    if (commit && paddr == REG_CTRL && state_reg == ST_IDLE)
    begin
      op_next     = poca_op_e'(pwdata[CTRL_OP_LSB +: 2]);
      signed_next = pwdata[CTRL_SIGNED_BIT];
    end
    if (commit && paddr == REG_OPA)
    begin
      opa_next = pwdata[WIDTH-1:0];
    end
    if (commit && paddr == REG_OPB)
    begin
      opb_next = pwdata[WIDTH-1:0];
    end
  end

  // Sequencer group.  Strobes are decoded from the next state so that each one
  // leaves a flip-flop in the cycle its state is current.
  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    ovf_seen_next = ovf_seen_reg;
    fin_next      = fin_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_req)
        begin
          state_next = ST_LDA;
          fin_next   = 1'b0;
        end
      end
      ST_LDA:    state_next = ST_LDB;
      ST_LDB:    state_next = ST_PREP;
      ST_PREP:   state_next = ST_HALF;
      ST_HALF:
      begin
        state_next = ST_WAIT;
        cnt_next   = 4'h0;
      end
      ST_WAIT:
      begin
        if (cnt_reg == HA_WAIT_LAST)
        begin
          state_next = ST_CARRY;
        end
        else
        begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      ST_CARRY:
      begin
        state_next = ST_SETTLE;
        cnt_next   = 4'h0;
      end
      ST_SETTLE:
      begin
        // The flag is only trusted once the ripple has settled.
        if (bus.done || cnt_reg == SETTLE_LAST)
        begin
          ovf_seen_next = bus.overflow;
          if (op_reg == OP_SUB_CMPL)
          begin
            state_next = ST_RECOMP;
          end
          else
          begin
            state_next = ST_IDLE;
            fin_next   = 1'b1;
          end
        end
        else
        begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      ST_RECOMP:
      begin
        state_next = ST_IDLE;
        fin_next   = 1'b1;
      end
      default:   state_next = ST_IDLE;
    endcase
    if (man_clr && state_reg == ST_IDLE)
    begin
      ovf_seen_next = 1'b0;
    end
  end

  // Strobe order: load_sum, load_addend, invert, complement, half_add,
  // carry_init, ovf_clear, add_active, signed_mode (bit 9 unused spare low).
  always_comb
  begin
    strobe_next    = 10'h000;
    operand_next   = operand_reg;
    strobe_next[0] = state_next == ST_LDA;
    strobe_next[1] = state_next == ST_LDB;
    strobe_next[2] = state_next == ST_PREP && op_reg == OP_SUB_INV;
    strobe_next[3] = (state_next == ST_PREP && op_reg == OP_SUB_CMPL) ||
                     state_next == ST_RECOMP;
    strobe_next[4] = state_next == ST_HALF;
    strobe_next[5] = state_next == ST_CARRY;
    strobe_next[6] = state_next == ST_PREP || (man_clr && state_reg == ST_IDLE);
    strobe_next[7] = state_next == ST_HALF || state_next == ST_WAIT ||
                     state_next == ST_CARRY || state_next == ST_SETTLE;
    strobe_next[8] = signed_reg;
    if (state_next == ST_LDA)
    begin
      operand_next = opa_reg;
    end
    else if (state_next == ST_LDB)
    begin
      operand_next = opb_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 4'h0;
      op_reg       <= OP_ADD;
      signed_reg   <= SIGNED_RESET;
      opa_reg      <= OPERAND_RESET;
      opb_reg      <= OPERAND_RESET;
      ovf_seen_reg <= 1'b0;
      fin_reg      <= 1'b0;
      pready_reg   <= 1'b0;
      prdata_reg   <= 32'h0000_0000;
      pslverr_reg  <= 1'b0;
      strobe_reg   <= 10'h000;
      operand_reg  <= OPERAND_RESET;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      op_reg       <= op_next;
      signed_reg   <= signed_next;
      opa_reg      <= opa_next;
      opb_reg      <= opb_next;
      ovf_seen_reg <= ovf_seen_next;
      fin_reg      <= fin_next;
      pready_reg   <= pready_next;
      prdata_reg   <= prdata_next;
      pslverr_reg  <= pslverr_next;
      strobe_reg   <= strobe_next;
      operand_reg  <= operand_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign bus.load_sum      = strobe_reg[0];
  assign bus.load_addend   = strobe_reg[1];
  assign bus.invert_addend = strobe_reg[2];
  assign bus.complement    = strobe_reg[3];
  assign bus.half_add      = strobe_reg[4];
  assign bus.carry_init    = strobe_reg[5];
  assign bus.ovf_clear     = strobe_reg[6];
  assign bus.add_active    = strobe_reg[7];
  assign bus.signed_mode   = strobe_reg[8];
  assign bus.operand       = operand_reg;

endmodule

// ==== src/poca_pkg.sv ====
// Shared constants and types for the one's complement adder and its sequencer.
// Assumes a single 25 MHz clock shared by both ends.
package poca_pkg;

  localparam int unsigned WIDTH           = 8;
  localparam int unsigned SIGN_BIT        = WIDTH - 1;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned HA_TO_CARRY_NS  = 500;
  localparam int unsigned SETTLE_MAX_NS   = 560;
  localparam int unsigned HA_TO_CARRY_CYC = (HA_TO_CARRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_MAX_CYC  = SETTLE_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  HA_WAIT_LAST    = 4'(HA_TO_CARRY_CYC - 2);
  localparam logic [3:0]  SETTLE_LAST     = 4'(SETTLE_MAX_CYC - 1);

  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_OPA         = 8'h04;
  localparam logic [7:0]  REG_OPB         = 8'h08;
  localparam logic [7:0]  REG_STATUS      = 8'h0c;
  localparam logic [7:0]  REG_RESULT      = 8'h10;

  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_OP_LSB     = 1;
  localparam int unsigned CTRL_SIGNED_BIT = 3;
  localparam int unsigned CTRL_OVFCLR_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_OVF_BIT    = 2;

  localparam logic        SIGNED_RESET    = 1'b0;
  localparam logic [7:0]  OPERAND_RESET   = 8'h00;

  typedef enum logic [1:0] {
    OP_ADD      = 2'h0,
    OP_SUB_CMPL = 2'h1,
    OP_SUB_INV  = 2'h2
  } poca_op_e;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_LDA    = 9'h002,
    ST_LDB    = 9'h004,
    ST_PREP   = 9'h008,
    ST_HALF   = 9'h010,
    ST_WAIT   = 9'h020,
    ST_CARRY  = 9'h040,
    ST_SETTLE = 9'h080,
    ST_RECOMP = 9'h100
  } poca_state_e;

endpackage

// ==== src/poca_if.sv ====
// Link between the step sequencer and the adder datapath.
// Both ends run on the same clock; every signal is driven from a flip-flop.
`timescale 1ns/1ps
interface poca_if;
  import poca_pkg::*;

  logic             load_sum;
  logic             load_addend;
  logic [WIDTH-1:0] operand;
  logic             invert_addend;
  logic             complement;
  logic             half_add;
  logic             carry_init;
  logic             ovf_clear;
  logic             add_active;
  logic             signed_mode;
  logic [WIDTH-1:0] sum;
  logic             overflow;
  logic             done;

  modport dev (
    input  load_sum, load_addend, operand, invert_addend, complement,
    input  half_add, carry_init, ovf_clear, add_active, signed_mode,
    output sum, overflow, done
  );

  modport ctl (
    output load_sum, load_addend, operand, invert_addend, complement,
    output half_add, carry_init, ovf_clear, add_active, signed_mode,
    input  sum, overflow, done
  );
endinterface

// ==== src/poca_adder.sv ====
// Eight-bit one's complement adder datapath with carry ripple and overflow flag.
// Assumes the sequencer issues one-cycle strobes, at most one datapath strobe per cycle.
`timescale 1ns/1ps
module poca_adder
  import poca_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  poca_if.dev       bus
);

  logic [WIDTH-1:0] running_sum_register_reg;
  logic [WIDTH-1:0] running_sum_register_next;
  logic [WIDTH-1:0] addend_reg;
  logic [WIDTH-1:0] addend_next;
  logic [WIDTH-1:0] pending_reg;
  logic [WIDTH-1:0] pending_next;
  logic [WIDTH-1:0] used_reg;
  logic [WIDTH-1:0] used_next;
  logic             ripple_reg;
  logic             ripple_next;
  logic             overflow_reg;
  logic             overflow_next;
  logic             sign_zero_reg;
  logic             sign_zero_next;
  logic             uf_armed_reg;
  logic             uf_armed_next;
  logic             done_reg;
  logic             done_next;

  logic [WIDTH-1:0] incoming;
  logic [WIDTH-1:0] carry_out;
  logic             wraparound_carry;
  logic             sign_carry;

  // The wraparound path exists only in signed mode; unsigned end carries go to the flag.
  assign wraparound_carry = pending_reg[SIGN_BIT] & bus.signed_mode;
  assign incoming         = {pending_reg[WIDTH-2:0], wraparound_carry};
  // A bit that already passed a carry in this phase never passes another.
  assign carry_out        = incoming & running_sum_register_reg & ~used_reg;
  assign sign_carry       = ripple_reg & incoming[SIGN_BIT];

  // Datapath group: operands, half-add, complement and carry ripple.
  always_comb
  begin
    running_sum_register_next = running_sum_register_reg;
    addend_next               = addend_reg;
    pending_next              = pending_reg;
    used_next                 = used_reg;
    ripple_next               = ripple_reg;
    if (bus.load_sum)
    begin
      running_sum_register_next = bus.operand;
      ripple_next               = 1'b0;
      pending_next              = '0;
    end
    if (bus.load_addend)
    begin
      addend_next = bus.operand;
    end
    if (bus.invert_addend)
    begin
      addend_next = ~addend_reg;
    end
    if (bus.complement)
    begin
      // Negative zero complements to positive zero and back, which is intended.
      running_sum_register_next = ~running_sum_register_reg;
    end
    if (bus.half_add)
    begin
      running_sum_register_next = running_sum_register_reg ^ addend_reg;
    end
    if (bus.carry_init)
    begin
      pending_next = ~running_sum_register_reg & addend_reg;
      used_next    = ~running_sum_register_reg & addend_reg;
      ripple_next  = 1'b1;
    end
    else if (ripple_reg)
    begin
      running_sum_register_next = running_sum_register_reg ^ incoming;
      pending_next              = carry_out;
      used_next                 = used_reg | carry_out;
      if (carry_out == '0)
      begin
        ripple_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      running_sum_register_reg <= '0;
      addend_reg               <= '0;
      pending_reg              <= '0;
      used_reg                 <= '0;
      ripple_reg               <= 1'b0;
    end
    else
    begin
      running_sum_register_reg <= running_sum_register_next;
      addend_reg               <= addend_next;
      pending_reg              <= pending_next;
      used_reg                 <= used_next;
      ripple_reg               <= ripple_next;
    end
  end

  // Overflow group.  A complement strobe never touches this flag because every
  // set term and every carry-driven clear is qualified by the add-in-progress level; ovf_clear is not.
  always_comb
  begin
    overflow_next  = overflow_reg;
    sign_zero_next = sign_zero_reg;
    uf_armed_next  = uf_armed_reg;
    if (bus.ovf_clear)
    begin
      overflow_next = 1'b0;
    end
    if (bus.half_add)
    begin
      sign_zero_next = ~(running_sum_register_reg[SIGN_BIT] ^ addend_reg[SIGN_BIT]);
      uf_armed_next  = running_sum_register_reg[SIGN_BIT] & addend_reg[SIGN_BIT];
    end
    if (bus.add_active && bus.signed_mode)
    begin
      if (bus.half_add && running_sum_register_reg[SIGN_BIT] && addend_reg[SIGN_BIT])
      begin
        overflow_next = 1'b1;
      end
      if (sign_carry && sign_zero_reg)
      begin
        if (uf_armed_reg)
        begin
          overflow_next = 1'b0;
        end
        else
        begin
          overflow_next = 1'b1;
        end
      end
    end
    if (bus.add_active && !bus.signed_mode && ripple_reg && pending_reg[SIGN_BIT])
    begin
      overflow_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      overflow_reg  <= 1'b0;
      sign_zero_reg <= 1'b0;
      uf_armed_reg  <= 1'b0;
    end
    else
    begin
      overflow_reg  <= overflow_next;
      sign_zero_reg <= sign_zero_next;
      uf_armed_reg  <= uf_armed_next;
    end
  end

  // Done group.  The worst case is a wraparound carry crossing every position,
  // about ten cycles, well inside the settling bound.
  always_comb
  begin
    done_next = done_reg;
    if (bus.half_add || bus.carry_init || bus.load_sum || bus.load_addend)
    begin
      done_next = 1'b0;
    end
    else if (ripple_reg && carry_out == '0)
    begin
      done_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= done_next;
    end
  end

  assign bus.sum      = running_sum_register_reg;
  assign bus.overflow = overflow_reg;
  assign bus.done     = done_reg;

endmodule

// ==== verification/poca_sva.sv ====
// Checker for the link between the step sequencer and the adder datapath.
// Assumes one clock; instantiated beside the interface with its signals as inputs.
`timescale 1ns/1ps
module poca_sva
  import poca_pkg::*;
(
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             load_sum,
  input wire logic             load_addend,
  input wire logic [WIDTH-1:0] operand,
  input wire logic             invert_addend,
  input wire logic             complement,
  input wire logic             half_add,
  input wire logic             carry_init,
  input wire logic             ovf_clear,
  input wire logic             add_active,
  input wire logic             signed_mode,
  input wire logic [WIDTH-1:0] sum,
  input wire logic             overflow,
  input wire logic             done
);
  logic [WIDTH-1:0] addend_reg, addend_next, exp_reg, exp_next;
  logic             eovf_reg, eovf_next, eact_reg, eact_next;
  logic [4:0]       gap_reg, gap_next;
  logic [8:0]       raw;

  // The addend is not visible on the link, so it is shadowed here from its strobes.
  always_comb
  begin
    addend_next = invert_addend ? ~addend_reg : (load_addend ? operand : addend_reg);
    raw = {1'b0, sum} + {1'b0, addend_reg};
    exp_next = exp_reg;
    eovf_next = eovf_reg;
    eact_next = eact_reg;
    gap_next = half_add ? 5'h01 : gap_reg + 5'(gap_reg != 5'h1f);
    if (half_add)
    begin
      exp_next = signed_mode ? raw[7:0] + {7'h00, raw[8]} : raw[7:0];
      eovf_next = signed_mode ? (sum[7] == addend_reg[7]) && (exp_next[7] != sum[7]) : raw[8];
      eact_next = add_active;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addend_reg <= '0;
      exp_reg <= '0;
      eovf_reg <= 1'b0;
      eact_reg <= 1'b0;
      gap_reg <= 5'h00;
    end
    else
    begin
      addend_reg <= addend_next;
      exp_reg <= exp_next;
      eovf_reg <= eovf_next;
      eact_reg <= eact_next;
      gap_reg <= gap_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_load; load_sum && !half_add && !complement |=> sum == $past(operand); endproperty
  a_load: assert property (p_load) else $error("load did not reach the sum");
  property p_half; half_add |=> sum == ($past(sum) ^ $past(addend_reg)); endproperty
  a_half: assert property (p_half) else $error("half-add result wrong");
  property p_comp; complement && !half_add |=> sum == ~$past(sum); endproperty
  a_comp: assert property (p_comp) else $error("complement wrong");
  property p_gap; carry_init |-> gap_reg >= 5'(HA_TO_CARRY_CYC); endproperty
  a_gap: assert property (p_gap) else $error("carry started too soon");
  property p_settle; carry_init |-> ##[2:14] done; endproperty
  a_settle: assert property (p_settle) else $error("ripple did not settle in time");
  property p_drop; half_add || carry_init |=> !done; endproperty
  a_drop: assert property (p_drop) else $error("done stayed high");
  property p_sum; $rose(done) |-> sum == exp_reg; endproperty
  a_sum: assert property (p_sum) else $error("settled sum wrong");
  property p_ovf; $rose(done) && eact_reg |-> overflow == eovf_reg; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_under; half_add && add_active && signed_mode && sum[7] && addend_reg[7] |=> overflow;
  endproperty
  a_under: assert property (p_under) else $error("underflow not armed");
  property p_clear; ovf_clear && !half_add && !carry_init |=> !overflow; endproperty
  a_clear: assert property (p_clear) else $error("overflow not cleared");
  property p_hold; done && !(load_sum || complement || half_add || carry_init) |=> $stable(sum);
  endproperty
  a_hold: assert property (p_hold) else $error("sum moved after settling");
endmodule

// ==== verification/tb_poca.sv ====
// Self-checking bench: APB stimulus into the sequencer, adder on the far side.
// Assumes the package offsets and status bit positions of the designer.
`timescale 1ns/1ps
module tb_poca;
  import poca_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          miscompares, num_checks, seed;
  logic [15:0] corner [6] = '{16'h0000, 16'hffff, 16'h7f01, 16'h8080, 16'hff00, 16'h01fe};

  poca_if pif();
  poca_adder poca_adder_inst (.clk(clk), .nrst(nrst), .bus(pif.dev));
  poca_seq poca_seq_inst (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(pif.ctl));
  poca_sva poca_sva_inst (.clk(clk), .nrst(nrst), .load_sum(pif.load_sum),
    .load_addend(pif.load_addend), .operand(pif.operand), .invert_addend(pif.invert_addend),
    .complement(pif.complement), .half_add(pif.half_add), .carry_init(pif.carry_init),
    .ovf_clear(pif.ovf_clear), .add_active(pif.add_active), .signed_mode(pif.signed_mode),
    .sum(pif.sum), .overflow(pif.overflow), .done(pif.done));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // The master holds the whole request until the edge where pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, exp_e});
  endtask

  function automatic logic [8:0] f_add(logic [7:0] a, logic [7:0] b, logic sg);
    logic [8:0] s;
    logic [7:0] r;
    s = {1'b0, a} + {1'b0, b};
    r = sg ? s[7:0] + {7'h00, s[8]} : s[7:0];
    return {sg ? (a[7] == b[7]) && (r[7] != a[7]) : s[8], r};
  endfunction

  // Overflow of the complement form is taken before the result is recomplemented.
  function automatic logic [8:0] exp_op(logic [7:0] a, logic [7:0] b, logic [1:0] op, logic sg);
    logic [8:0] t;
    t = (op == 2'h1) ? f_add(~a, b, sg) : f_add(a, (op == 2'h2) ? ~b : b, sg);
    return (op == 2'h1) ? {t[8], ~t[7:0]} : t;
  endfunction

  task run_op(input logic [7:0] a, input logic [7:0] b, input logic [1:0] op,
              input logic sg, input logic dbl);
    logic [8:0]  x;
    logic [31:0] q;
    logic        e;
    int          n;
    x = exp_op(a, b, op, sg);
    wr(REG_OPA, {24'h0, a});
    wr(REG_OPB, {24'h0, b});
    wr(REG_CTRL, {28'h0, sg, op, 1'b1});
    // A second order while busy must change nothing, overflow clear included.
    if (dbl)
    begin
      wr(REG_CTRL, 32'h1f);
      rd(REG_CTRL, {28'h0, sg, op, 1'b0}, 1'b0);
    end
    for (n = 0; n < 40; n++)
    begin
      apb(1'b0, REG_STATUS, 32'h0, q, e);
      if (q[STAT_DONE_BIT] === 1'b1)
        break;
    end
    chk(q, {29'h0, x[8], 2'b10});
    rd(REG_RESULT, {24'h0, x[7:0]}, 1'b0);
    if (n >= 40)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    num_checks = 0;
    seed = 32'h98ce;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_CTRL, 32'h0, 1'b0);
    rd(REG_STATUS, 32'h0, 1'b0);
    rd(REG_RESULT, 32'h0, 1'b0);
    $display("test reset done");
    wr(8'h14, 32'h5a);
    rd(8'h14, 32'h0, 1'b1);
    $display("test unmapped done");
    for (int i = 0; i < 6; i++)
      for (int k = 0; k < 8; k++)
        run_op(corner[i][15:8], corner[i][7:0], k[1:0], k[2], 1'b0);
    $display("test corners done");
    for (int i = 0; i < 32; i++)
      run_op(8'($random(seed)), 8'($random(seed)), 2'($random(seed)), 1'($random(seed)),
             1'($random(seed)));
    $display("test random done");
    wrap_up();
  end
endmodule
